// file: include/sdram_map.svh
/*
  Constants of the x8 DDR3 memory core: pin bundle layout, command codes,
  burst lengths, burst-mode selections and core sizes.
  Assumes it is included by bare name from the package and the design file.
*/
`ifndef SDRAM_MAP_SVH
`define SDRAM_MAP_SVH

// ----------------------------------------------------------------------------
// Sampled pin bundle layout (bit positions)
// ----------------------------------------------------------------------------
`define PIN_W        38
`define P_DM         0
`define P_DQSN       1
`define P_DQSP       2
`define P_DQ         3
`define P_A          11
`define P_BA         27
`define P_RSTN       30
`define P_ODT        31
`define P_WE         32
`define P_CAS        33
`define P_RAS        34
`define P_CSN        35
`define P_CKE        36
`define P_CK         37

// ----------------------------------------------------------------------------
// Command codes as {ras_n, cas_n, we_n} with chip select low
// ----------------------------------------------------------------------------
`define CMD_ACT      3'h3
`define CMD_READ     3'h5
`define CMD_WRITE    3'h4
`define CMD_PRE      3'h2

// ----------------------------------------------------------------------------
// Burst lengths in transfers and burst-mode selections
// ----------------------------------------------------------------------------
`define BURST_FULL   4'h8
`define BURST_CHOP   4'h4
`define BL_FIXED8    2'h0
`define BL_OTF       2'h1
`define BL_FIXED4    2'h2

// ----------------------------------------------------------------------------
// Core sizes and read latency in link clock cycles
// ----------------------------------------------------------------------------
`define NUM_BANKS    8
`define MEM_WORDS    128
`define READ_LAT     3'h5
`define FIFO_DEPTH   16
`define FIFO_WIDTH   8

`endif

// file: include/sdram_pkg.sv
/*
  Types of the x8 DDR3 memory core: sequencer states and the state record.
  Assumes sdram_map.svh is on the include path.
*/
`include "sdram_map.svh"

package sdram_pkg;

  // --------------------------------------------------------------------------
  // Access sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_RD_WAIT, ST_RD_DATA} state_t;

  // --------------------------------------------------------------------------
  // Whole state of the memory core
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`PIN_W-1:0]                meta;      // Pin synchroniser, first stage
    logic [`PIN_W-1:0]                pins;      // Pin synchroniser, second stage
    logic                             ck_prev;   // Link clock, previous sample
    logic                             dqs_prev;  // Write strobe, previous sample
    logic [`MEM_WORDS-1:0][63:0]      mem;       // Array of 8n-bit core words
    logic [`NUM_BANKS-1:0]            bank_open; // Row open per bank
    logic [`NUM_BANKS-1:0][15:0]      row;       // Open row per bank
    state_t                           state;     // Access sequencer
    logic [2:0]                       bank;      // Bank of current burst
    logic [9:0]                       col;       // Start column of burst
    logic                             ap;        // Auto precharge at burst end
    logic                             chop;      // Burst of four
    logic [3:0]                       beat;      // Transfers done
    logic [2:0]                       lat;       // Read latency count
    logic [63:0]                      word;      // Prefetch word
    logic [7:0]                       wen;       // Written, unmasked bytes
    logic [3:0]                       push;      // Read bytes queued
    logic                             pushing;   // Read queueing active
    logic [7:0]                       dq;        // Read data driven
    logic                             dqs;       // Read strobe driven
    logic                             dqs_oe;    // Strobe and data driven
  } core_t;

endpackage : sdram_pkg

// file: design/sdram_device.sv
/*
  Device-side access logic of an eight-bank x8 DDR3 memory, with the read
  byte FIFO. Assumes every link pin, the true clock included, is sampled on
  mclk_in, which runs well above the link clock, and that mode bits are
  static configuration from logic on mclk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdram_map.svh"

// ----------------------------------------------------------------------------
// Read byte FIFO
// ----------------------------------------------------------------------------
module sdram_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rstn_in,
  input  wire logic             clr_in,
  // Fill side
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // Drain side
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Entries
    logic [AW-1:0]               wp;   // Write index
    logic [AW-1:0]               rp;   // Read index
    logic [AW:0]                 cnt;  // Fill level
  } fifo_t;
  fifo_t s_ff;
  fifo_t nxt_s;

  // Honest flags from the fill level
  assign wr_ready_out = s_ff.cnt != (AW+1)'(DEPTH);
  assign rd_valid_out = s_ff.cnt != '0;
  assign rd_data_out  = s_ff.mem[s_ff.rp];

  // Push and pop
  always_comb
  begin
    nxt_s = s_ff;
    if (wr_valid_in && wr_ready_out)
    begin
      nxt_s.mem[s_ff.wp] = wr_data_in;
      nxt_s.wp = s_ff.wp + 1'b1;
    end
    if (rd_ready_in && rd_valid_out)
      nxt_s.rp = s_ff.rp + 1'b1;
    nxt_s.cnt = s_ff.cnt + (AW+1)'(wr_valid_in && wr_ready_out)
                         - (AW+1)'(rd_ready_in && rd_valid_out);
    if (clr_in)
    begin
      nxt_s.wp  = '0;
      nxt_s.rp  = '0;
      nxt_s.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end
endmodule : sdram_fifo

// ----------------------------------------------------------------------------
// Memory core
// ----------------------------------------------------------------------------
// How it works
// - Strobe driven by memory only for reads
// - Read strobe edges align with data edges
// - Strobe always a complementary pair
// - Termination strobe mirrors strobe termination when enabled
// - Otherwise shared pin is write mask
// - Eight banks, 8n prefetch word
// - One word becomes eight byte transfers, four in a chopped burst
// - Bursts of eight or four, programmed order
// - Activate takes bank and row
// - Access takes column and precharge request
// - On-the-fly mode lets A12 choose length
// - A10 high precharges bank after burst
// - A12 high full burst, low chopped
// - Chip select high ignores command
// - Command decoded from strobes sampled together
module sdram_device (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // Link clock, command and address pins
  input  wire logic        ck_in,
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [2:0]  ba_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        odt_in,
  input  wire logic        reset_n_in,
  // Data and strobe pins
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq_out,
  output logic             dq_oe_out,
  input  wire logic        dqs_in,
  output logic             dqs_out,
  output logic             dqs_oe_out,
  input  wire logic        dqs_n_in,
  output logic             dqs_n_out,
  output logic             dqs_n_oe_out,
  input  wire logic        dm_tdqs_in,
  output logic             dm_tdqs_out,
  output logic             dm_tdqs_oe_out,
  output logic             tdqs_n_out,
  output logic             tdqs_n_oe_out,
  // Termination enables
  output logic             dqs_term_out,
  output logic             tdqs_term_out,
  // Mode bits
  input  wire logic        tdqs_en_in,
  input  wire logic [1:0]  bl_mode_in,
  input  wire logic        burst_ilv_in,
  // Status
  output logic [7:0]       bank_open_out,
  output logic             rd_busy_out
);
  sdram_pkg::core_t s;       // Registered state
  sdram_pkg::core_t nxt_s;   // Next state
  logic        ck_rise;      // Link clock rising edge seen
  logic        ck_edge;      // Either link clock edge seen
  logic        cmd_ok;       // Command strobe this cycle
  logic [2:0]  cmd;          // Decoded command code
  logic [2:0]  cba;          // Command bank
  logic [15:0] ca;           // Command address
  logic        dqs_beat;     // Valid write strobe edge
  logic [3:0]  len;          // Length of current burst
  logic [2:0]  widx;         // Byte slot of next write beat
  logic [6:0]  cidx;         // Core word index of burst
  logic [63:0] merged;       // Write word merged with array
  logic        fifo_wr_ready;
  logic        fifo_rd_valid;
  logic        fifo_rd_ready;
  logic [7:0]  fifo_rd_data;

  // Byte slot of transfer i in a burst from start column c
  function automatic logic [2:0] slot(input logic [2:0] c, input logic [2:0] i,
                                      input logic ch, input logic ilv);
    if (ilv)
      slot = c ^ i;
    else if (ch)
      slot = {c[2], c[1:0] + i[1:0]};
    else
      slot = c + i;
  endfunction : slot

  // --------------------------------------------------------------------------
  // Edge and command decode
  // --------------------------------------------------------------------------
  assign ck_rise  = s.pins[`P_CK] && !s.ck_prev;
  assign ck_edge  = s.pins[`P_CK] != s.ck_prev;
  assign cmd_ok   = ck_rise && s.pins[`P_CKE] && !s.pins[`P_CSN] && s.pins[`P_RSTN];
  assign cmd      = s.pins[`P_RAS:`P_WE];
  assign cba      = s.pins[`P_BA+2:`P_BA];
  assign ca       = s.pins[`P_A+15:`P_A];
  assign dqs_beat = (s.pins[`P_DQSP] != s.dqs_prev) && (s.pins[`P_DQSP] != s.pins[`P_DQSN]);
  assign len      = s.chop ? `BURST_CHOP : `BURST_FULL;
  assign widx     = slot(s.col[2:0], s.beat[2:0], s.chop, burst_ilv_in);
  assign cidx     = {s.bank, s.col[6:3]};

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_merge
      assign merged[8*g +: 8] = s.wen[g] ? s.word[8*g +: 8] : s.mem[cidx][8*g +: 8];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read byte queue
  // --------------------------------------------------------------------------
  // Word leaves as byte transfers
  assign fifo_rd_ready = (s.state == sdram_pkg::ST_RD_DATA) && ck_edge && (s.beat != len);
  sdram_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) sdram_fifo_i (
    .mclk_in      (mclk_in),
    .rstn_in      (rstn_in),
    .clr_in       (!s.pins[`P_RSTN]),
    .wr_valid_in  (s.pushing),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   (s.word[8*slot(s.col[2:0], s.push[2:0], s.chop, burst_ilv_in) +: 8]),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_rd_ready),
    .rd_data_out  (fifo_rd_data)
  );

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_s = s;
    nxt_s.meta = {ck_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, odt_in,
                  reset_n_in, ba_in, addr_in, dq_in, dqs_in, dqs_n_in, dm_tdqs_in};
    nxt_s.pins     = s.meta;
    nxt_s.ck_prev  = s.pins[`P_CK];
    nxt_s.dqs_prev = s.pins[`P_DQSP];
    // Queue stalls while the FIFO is full
    if (s.pushing && fifo_wr_ready)
    begin
      nxt_s.push = s.push + 4'h1;
      if (s.push == len - 4'h1)
        nxt_s.pushing = 1'b0;
    end
    // Bank open and close commands
    if (cmd_ok && cmd == `CMD_ACT)
    begin
      nxt_s.bank_open[cba] = 1'b1;
      nxt_s.row[cba]       = ca;
    end
    else if (cmd_ok && cmd == `CMD_PRE)
    begin
      if (ca[10])
        nxt_s.bank_open = '0;
      else
        nxt_s.bank_open[cba] = 1'b0;
    end
    unique case (s.state)
      // Accept an access to an open bank
      sdram_pkg::ST_IDLE:
      begin
        if (cmd_ok && (cmd == `CMD_READ || cmd == `CMD_WRITE) && s.bank_open[cba])
        begin
          nxt_s.bank = cba;
          nxt_s.col  = ca[9:0];
          nxt_s.ap   = ca[10];
          nxt_s.chop = (bl_mode_in == `BL_FIXED4) || (bl_mode_in == `BL_OTF && !ca[12]);
          nxt_s.beat = '0;
          nxt_s.wen  = '0;
          nxt_s.lat  = '0;
          nxt_s.word = s.mem[{cba, ca[6:3]}];
          if (cmd == `CMD_READ)
          begin
            nxt_s.state   = sdram_pkg::ST_RD_WAIT;
            nxt_s.push    = '0;
            nxt_s.pushing = 1'b1;
          end
          else
            nxt_s.state = sdram_pkg::ST_WRITE;
        end
      end
      // Collect write beats on strobe edges, then commit the word
      sdram_pkg::ST_WRITE:
      begin
        if (s.beat == len)
        begin
          nxt_s.mem[cidx] = merged;
          nxt_s.state     = sdram_pkg::ST_IDLE;
          if (s.ap)
            nxt_s.bank_open[s.bank] = 1'b0;
        end
        else if (dqs_beat)
        begin
          nxt_s.word[8*widx +: 8] = s.pins[`P_DQ+7:`P_DQ];
          nxt_s.wen[widx] = !(s.pins[`P_DM] && !tdqs_en_in);
          nxt_s.beat      = s.beat + 4'h1;
        end
      end
      // Count latency, then drive the preamble
      sdram_pkg::ST_RD_WAIT:
      begin
        if (ck_rise)
        begin
          nxt_s.lat = s.lat + 3'h1;
          if (s.lat == `READ_LAT - 3'h1)
          begin
            nxt_s.dqs_oe = 1'b1;
            nxt_s.dqs    = 1'b0;
            nxt_s.state  = sdram_pkg::ST_RD_DATA;
          end
        end
      end
      // One byte per link clock edge
      sdram_pkg::ST_RD_DATA:
      begin
        if (ck_edge)
        begin
          if (s.beat != len)
          begin
            nxt_s.dq   = fifo_rd_data;
            nxt_s.dqs  = !s.dqs;
            nxt_s.beat = s.beat + 4'h1;
          end
          else
          begin
            nxt_s.dqs_oe = 1'b0;
            nxt_s.state  = sdram_pkg::ST_IDLE;
            if (s.ap)
              nxt_s.bank_open[s.bank] = 1'b0;
          end
        end
      end
    endcase
    // Reset pin closes all banks, idles the sequencer and stops queueing and strobe drive
    if (!s.pins[`P_RSTN])
    begin
      nxt_s.bank_open = '0;
      nxt_s.state     = sdram_pkg::ST_IDLE;
      nxt_s.pushing   = 1'b0;
      nxt_s.dqs_oe    = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      s <= '0;
    else
      s <= nxt_s;
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  assign dq_out         = s.dq;
  assign dq_oe_out      = s.dqs_oe;
  assign dqs_out        = s.dqs;
  assign dqs_oe_out     = s.dqs_oe;
  assign dqs_n_out      = !s.dqs;
  assign dqs_n_oe_out   = s.dqs_oe;
  assign dm_tdqs_out    = 1'b0;
  assign dm_tdqs_oe_out = 1'b0;
  assign tdqs_n_out     = 1'b0;
  assign tdqs_n_oe_out  = 1'b0;
  assign dqs_term_out   = s.pins[`P_ODT] && s.pins[`P_RSTN] && !s.dqs_oe;
  assign tdqs_term_out  = dqs_term_out && tdqs_en_in;
  assign bank_open_out  = s.bank_open;
  assign rd_busy_out    = s.state == sdram_pkg::ST_RD_WAIT || s.state == sdram_pkg::ST_RD_DATA;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  AST_DQS_DIR: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s.dqs_oe |-> s.state == sdram_pkg::ST_RD_DATA) else $error("strobe driven outside read");
  AST_EDGE_ALIGN: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s.dqs_oe && $past(s.dqs_oe) && $changed(s.dq) |-> $changed(s.dqs))
    else $error("read data moved without strobe edge");
  AST_DQS_PAIR: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    dqs_oe_out |-> dqs_n_oe_out && dqs_n_out == !dqs_out) else $error("strobe pair broken");
  AST_TDQS_TERM: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    tdqs_term_out |-> tdqs_en_in && dqs_term_out) else $error("termination strobe mismatch");
  AST_MASK: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s.state == sdram_pkg::ST_WRITE && s.beat != len && dqs_beat && s.pins[`P_DM] && !tdqs_en_in
    |=> !s.wen[$past(widx)]) else $error("masked byte written");
  AST_BURST_LEN: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    $fell(s.dqs_oe) && s.pins[`P_RSTN] |-> $past(s.beat) == ($past(s.chop) ? 4'h4 : 4'h8))
    else $error("read burst length wrong");
  AST_ACT_OPENS: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    cmd_ok && cmd == `CMD_ACT |=> s.bank_open[$past(cba)] && s.row[$past(cba)] == $past(ca))
    else $error("activate did not open row");
  AST_CHOP: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s.state == sdram_pkg::ST_IDLE && cmd_ok && cmd == `CMD_READ && s.bank_open[cba]
    && bl_mode_in == `BL_OTF |=> s.chop == !$past(ca[12])) else $error("A12 chop wrong");
  AST_AUTO_PRE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s.state == sdram_pkg::ST_RD_DATA && ck_edge && s.beat == len && s.ap
    |=> !s.bank_open[$past(s.bank)]) else $error("auto precharge missed");
  AST_CS_IGNORE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s.state == sdram_pkg::ST_IDLE && ck_rise && s.pins[`P_CSN] && s.pins[`P_RSTN]
    |=> s.state == sdram_pkg::ST_IDLE && $stable(s.bank_open)) else $error("deselect acted");
  AST_CKE_LOW: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    s.state == sdram_pkg::ST_IDLE && !s.pins[`P_CKE] && s.pins[`P_RSTN]
    |=> s.state == sdram_pkg::ST_IDLE && $stable(s.bank_open)) else $error("command with cke low");
endmodule : sdram_device

`default_nettype wire

// file: tb/sdram_ctrl_model.sv
/*
  Behavioural DDR3 controller: link clock, power-up, commands, write bursts, read capture.
  Assumes the bench resolves the shared data and strobe lines.
*/
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model (
  // System clock
  input  wire logic        mclk_in,
  // Command pins
  output logic             ck_out,
  output logic             cke_out,
  output logic             cs_n_out,
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic [2:0]       ba_out,
  output logic [15:0]      addr_out,
  output logic             reset_n_out,
  // Data pins
  output logic [7:0]       dq_out,
  output logic             dqs_out,
  output logic             dm_out,
  input  wire logic [7:0]  dq_in,
  input  wire logic        dqs_in,
  input  wire logic        dqs_n_in,
  input  wire logic        oe_in
);
  // Idle pins, then a free link clock out of phase with mclk
  initial
  begin
    {ck_out, cke_out, reset_n_out, dqs_out, dm_out} = 5'h00;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
    {ba_out, addr_out, dq_out} = 27'h000_0000;
    #3;
    forever #80 ck_out = ~ck_out;
  end
  task automatic power_up();
    #200_000 reset_n_out = 1'b1;
    @(negedge ck_out);
    cke_out = 1'b1;
  endtask : power_up
  task automatic cmd(input logic [2:0] c, input logic cs_n, input logic [2:0] ba,
                     input logic [15:0] a);
    @(negedge ck_out);
    {ras_n_out, cas_n_out, we_n_out} = c;
    cs_n_out = cs_n;
    ba_out = ba;
    addr_out = a;
    @(negedge ck_out);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
    addr_out = ~a;
  endtask : cmd
  task automatic wr(input logic [63:0] d, input logic [7:0] m, input int n);
    // Quarter-bit offset keeps the burst end clear of a link clock fall
    #20;
    for (int i = 0; i < n; i++)
    begin
      dq_out = d[8*i +: 8];
      dm_out = m[i];
      #40 dqs_out = ~dqs_out;
      #40;
    end
    dq_out = ~dq_out;
  endtask : wr
  // Read capture on each device strobe edge
  task automatic rd(input int n, output logic [63:0] d, output logic ok);
    d = 64'h0000_0000_0000_0000;
    for (int k = 0; k < 100 && oe_in !== 1'b1; k++) @(posedge mclk_in);
    #1 ok = (dqs_in === 1'b0);
    for (int i = 0; i < n; i++)
    begin
      @(dqs_in);
      #1 d[8*i +: 8] = dq_in;
      ok &= (dqs_n_in === ~dqs_in);
    end
    for (int k = 0; k < 100 && oe_in !== 1'b0; k++) @(posedge mclk_in);
  endtask : rd
endmodule : sdram_ctrl_model
`default_nettype wire

// file: tb/sdram_access_and_powerup_tb.sv
/*
  Self-checking bench of the DDR3 device core against a controller model.
  Assumes sdram_map.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdram_map.svh"
module sdram_access_and_powerup_tb;
  logic mclk_in = 1'b0, rstn_in, odt_in, tdqs_en_in, burst_ilv_in, ok;
  logic [1:0] bl_mode_in;
  logic [63:0] d, w, e;
  int errors = 0, checked = 0;
  wire logic ck, cke, cs_n, ras_n, cas_n, we_n, rst_n, c_dqs, dm, dq_oe, dqs_o, dqs_n_o, dqs_oe;
  wire logic dm_oe, tn_oe, t_dqs, t_tdqs, busy;
  wire logic [2:0] ba;
  wire logic [15:0] addr;
  wire logic [7:0] c_dq, d_dq, bank_open;
  // Shared lines: device drives while its enable is up, else the controller
  wire logic [7:0] dq_line = dq_oe ? d_dq : c_dq;
  wire logic dqs_line = dqs_oe ? dqs_o : c_dqs;
  always #10 mclk_in = ~mclk_in;
  sdram_device sdram_device_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .ck_in(ck), .cke_in(cke),
    .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba),
    .addr_in(addr), .odt_in(odt_in), .reset_n_in(rst_n), .dq_in(dq_line), .dq_out(d_dq),
    .dq_oe_out(dq_oe), .dqs_in(dqs_line), .dqs_out(dqs_o), .dqs_oe_out(dqs_oe),
    .dqs_n_in(~dqs_line), .dqs_n_out(dqs_n_o), .dqs_n_oe_out(), .dm_tdqs_in(dm),
    .dm_tdqs_out(), .dm_tdqs_oe_out(dm_oe), .tdqs_n_out(), .tdqs_n_oe_out(tn_oe),
    .dqs_term_out(t_dqs), .tdqs_term_out(t_tdqs), .tdqs_en_in(tdqs_en_in),
    .bl_mode_in(bl_mode_in), .burst_ilv_in(burst_ilv_in), .bank_open_out(bank_open),
    .rd_busy_out(busy));
  sdram_ctrl_model sdram_ctrl_model_i (.mclk_in(mclk_in), .ck_out(ck), .cke_out(cke),
    .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba),
    .addr_out(addr), .reset_n_out(rst_n), .dq_out(c_dq), .dqs_out(c_dqs), .dm_out(dm),
    .dq_in(d_dq), .dqs_in(dqs_o), .dqs_n_in(dqs_n_o), .oe_in(dq_oe));
  // Compare and count
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Verdict and end of run
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Watchdog against a hang
  initial
  begin
    #1_000_000 errors++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    {rstn_in, odt_in, tdqs_en_in, burst_ilv_in, bl_mode_in} = 6'h00;
    repeat (20) @(negedge mclk_in);
    rstn_in = 1'b1;
    chk("idle", {bank_open, dq_oe, dqs_oe}, 64'h0000_0000_0000_0000);
    sdram_ctrl_model_i.power_up();
    sdram_ctrl_model_i.cmd(`CMD_ACT, 1'b1, 3'h5, 16'h0000);
    sdram_ctrl_model_i.cmd(`CMD_ACT, 1'b0, 3'h2, 16'h1234);
    chk("open", bank_open, 64'h0000_0000_0000_0004);
    w = 64'h8877_6655_4433_2211;
    sdram_ctrl_model_i.cmd(`CMD_WRITE, 1'b0, 3'h2, 16'h1000);
    sdram_ctrl_model_i.wr(w, 8'h00, 8);
    sdram_ctrl_model_i.cmd(`CMD_WRITE, 1'b0, 3'h2, 16'h1000);
    sdram_ctrl_model_i.wr(64'h1f1e_1d1c_1b1a_1918, 8'h02, 8);
    e = {48'h1f1e_1d1c_1b1a, w[15:8], 8'h18};
    sdram_ctrl_model_i.cmd(`CMD_READ, 1'b0, 3'h2, 16'h1000);
    chk("busy", busy, 64'h0000_0000_0000_0001);
    sdram_ctrl_model_i.rd(8, d, ok);
    chk("rd_seq", d, e);
    chk("strobe", {ok, busy, bank_open}, 64'h0000_0000_0000_0204);
    @(negedge mclk_in);
    burst_ilv_in = 1'b1;
    sdram_ctrl_model_i.cmd(`CMD_READ, 1'b0, 3'h2, 16'h1003);
    sdram_ctrl_model_i.rd(8, d, ok);
    for (int i = 0; i < 8; i++) w[8*i +: 8] = e[8*(3 ^ i) +: 8];
    chk("rd_ilv", d, w);
    @(negedge mclk_in);
    {burst_ilv_in, bl_mode_in} = 3'h1;
    sdram_ctrl_model_i.cmd(`CMD_READ, 1'b0, 3'h2, 16'h0402);
    sdram_ctrl_model_i.rd(4, d, ok);
    w = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 4; i++) w[8*i +: 8] = e[8*((2 + i) % 4) +: 8];
    chk("rd_chop", d, w);
    chk("rd_ap", bank_open, 64'h0000_0000_0000_0000);
    sdram_ctrl_model_i.cmd(`CMD_ACT, 1'b0, 3'h2, 16'h0001);
    @(negedge mclk_in);
    bl_mode_in = 2'h2;
    sdram_ctrl_model_i.cmd(`CMD_READ, 1'b0, 3'h2, 16'h1000);
    sdram_ctrl_model_i.rd(4, d, ok);
    chk("rd_fix4", {ok, dq_oe, d[31:0]}, {2'h2, e[31:0]});
    @(negedge mclk_in);
    {odt_in, tdqs_en_in} = 2'h3;
    repeat (4) @(negedge mclk_in);
    chk("term_on", {t_dqs, t_tdqs, dm_oe, tn_oe}, 64'h0000_0000_0000_000c);
    tdqs_en_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    chk("term_off", {t_dqs, t_tdqs, dm_oe, tn_oe}, 64'h0000_0000_0000_0008);
    complete_run();
  end
endmodule : sdram_access_and_powerup_tb
`default_nettype wire
